/* File: smia_defs.vh */
// Constants for the shared memory interface and bus arbiter
`ifndef SMIA_DEFS_VH
`define SMIA_DEFS_VH

// Memory organisations selectable by software
`define SMIA_KIND_SRAM128 3'h0
`define SMIA_KIND_SRAM512 3'h1
`define SMIA_KIND_DRAM256 3'h2
`define SMIA_KIND_DRAM1M 3'h3
`define SMIA_KIND_DRAM4M 3'h4

// Processor address fields
`define SMIA_A_BYTE 0
`define SMIA_A_CE_LO 18
`define SMIA_A_CE_HI 19
`define SMIA_SRAM128_WORD 17:1
`define SMIA_SRAM512_WORD 19:1
`define SMIA_D256_RAS_LO 19
`define SMIA_D256_RAS_HI 20
`define SMIA_D256_ROW 18:10
`define SMIA_D256_COL 9:1
`define SMIA_D1M_RAS_LO 20
`define SMIA_D1M_RAS_HI 22
`define SMIA_D1M_ROW 20:11
`define SMIA_D1M_COL 10:1
`define SMIA_D4M_RAS 23
`define SMIA_D4M_ROW 22:12
`define SMIA_D4M_COL 11:1

// Requester slots, highest priority first
`define SMIA_RQ_RX 0
`define SMIA_RQ_CPU 1
`define SMIA_RQ_TX 2
`define SMIA_RQ_IC 3
`define SMIA_RQ_REF 4
`define SMIA_RQ_N 5

// Timing
`define SMIA_CLK_PERIOD_NS 20
`define SMIA_TOKEN_PULSE_NS 30
`define SMIA_MIN_DRAM_LEN 4'h2
// Strap is only trusted once it has crossed both sync stages
`define SMIA_INIT_DONE 2'h3

`endif

/* File: smia_addr_map.v */
// Address decoder: chip enables, row/column strobes and address split
`include "smia_defs.vh"

module smia_addr_map (
  // Request
  input wire [23:0] addr,
  input wire [2:0] kind,
  input wire byte_xfer,
  // Decoded selects
  output reg [7:0] ce_n,
  output reg [3:0] ras_n,
  output reg [1:0] cas_n,
  // Address parts
  output reg [18:0] word_addr,
  output reg [10:0] row,
  output reg [10:0] col
);

  function [7:0] dec8;
    input [2:0] idx;
    begin
      dec8 = ~(8'h01 << idx);
    end
  endfunction

  function [3:0] dec4;
    input [1:0] idx;
    begin
      dec4 = ~(4'h1 << idx);
    end
  endfunction

  wire a0;
  assign a0 = addr[`SMIA_A_BYTE];

  always @* begin
    ce_n = 8'hff;
    ras_n = 4'hf;
    cas_n = 2'h3;
    word_addr = 19'h0;
    row = 11'h0;
    col = 11'h0;
    case (kind)
      `SMIA_KIND_SRAM128: begin
        ce_n = dec8({addr[`SMIA_A_CE_HI], addr[`SMIA_A_CE_LO], a0}); // RULE_03 RULE_04
        word_addr = {2'h0, addr[`SMIA_SRAM128_WORD]}; // RULE_05
      end
      `SMIA_KIND_SRAM512: begin
        ce_n = dec8({2'h0, a0}); // RULE_06
        word_addr = addr[`SMIA_SRAM512_WORD]; // RULE_06
      end
      `SMIA_KIND_DRAM256: begin
        ras_n = dec4({addr[`SMIA_D256_RAS_HI], addr[`SMIA_D256_RAS_LO]}); // RULE_10
        row = {2'h0, addr[`SMIA_D256_ROW]}; // RULE_10
        col = {2'h0, addr[`SMIA_D256_COL]};
      end
      `SMIA_KIND_DRAM1M: begin
        ras_n = dec4({addr[`SMIA_D1M_RAS_HI], addr[`SMIA_D1M_RAS_LO]}); // RULE_11
        row = {1'h0, addr[`SMIA_D1M_ROW]}; // RULE_11
        col = {1'h0, addr[`SMIA_D1M_COL]};
      end
      `SMIA_KIND_DRAM4M: begin
        ras_n = dec4({1'b0, addr[`SMIA_D4M_RAS]}); // RULE_12
        row = addr[`SMIA_D4M_ROW]; // RULE_12
        col = addr[`SMIA_D4M_COL];
      end
      default: begin
        ce_n = 8'hff;
      end
    endcase
    // One column strobe per byte, both for a word
    if (byte_xfer) begin
      cas_n = a0 ? 2'h1 : 2'h2; // RULE_08
    end else begin
      cas_n = 2'h0; // RULE_08
    end
  end

endmodule // smia_addr_map

/* File: smia_arbiter.v */
// Shared memory arbiter, SRAM/DRAM cycle engine and token ring handling
// Functional notes
// (RULE_01) Cycle length is p clocks, per type; DRAM and refresh cycles are held to at least 2 clocks
// (RULE_02) SRAM space is 1 Mbyte, 16-bit words
// (RULE_03) SRAM: one of eight enables from A19,A18,A0
// (RULE_04) Enables pick upper or lower byte
// (RULE_05) 128K SRAM: address lines from A1..A17
// (RULE_06) 512K SRAM: A1..A19, enables by A0
// (RULE_07) DRAM 16 Mbyte, 11 lines, 4 RAS, 2 CAS
// (RULE_08) One RAS per bank; CAS by A0 or both
// (RULE_09) Programmable RAS-only refresh over all rows
// (RULE_10) 256K DRAM: RAS by A20,A19; 9+9 bits
// (RULE_11) 1M DRAM: RAS by A22,A20; 10+10 bits
// (RULE_12) 4M DRAM: RAS by A23; 11+11 bits
// (RULE_13) Priority: rx, cpu, tx, interrupt, refresh
// (RULE_14) Token ring shares memory between chained devices
// (RULE_15) Pass token with 30 ns output pulse
// (RULE_16) Processor uses memory select for memory
// (RULE_17) Access memory only while holding token
// (RULE_18) A started cycle finishes before regrant
`include "smia_defs.vh"

module smia_arbiter (
  // Clock and reset
  input wire clk,
  input wire rst_b,
  // Configuration from the register block
  input wire [2:0] mem_kind,
  input wire [3:0] sram_cycle_len,
  input wire [3:0] dram_cycle_len,
  input wire [11:0] refresh_period,
  input wire chain_enable,
  // Receive DMA
  input wire rx_req,
  input wire [23:0] rx_addr,
  input wire rx_byte,
  input wire rx_write,
  output wire rx_done,
  // Transmit DMA
  input wire tx_req,
  input wire [23:0] tx_addr,
  input wire tx_byte,
  input wire tx_write,
  output wire tx_done,
  // Interrupt controller
  input wire ic_req,
  input wire [23:0] ic_addr,
  input wire ic_byte,
  input wire ic_write,
  output wire ic_done,
  // Processor pins
  input wire memory_select_n,
  input wire [23:0] cpu_addr,
  input wire cpu_byte,
  input wire cpu_write,
  output wire cpu_ready,
  // Memory pins
  output wire [7:0] chip_enable_n,
  output wire [3:0] row_strobe_n,
  output wire [1:0] column_strobe_n,
  output wire [18:0] memory_address_bus,
  output wire mem_write_n,
  // Token ring pins
  input wire token_in,
  input wire token_first,
  output wire token_out
);

  localparam ST_IDLE = 5'h01;
  localparam ST_SRAM = 5'h02;
  localparam ST_ROW = 5'h04;
  localparam ST_COL = 5'h08;
  // Refresh shares the single-phase end path but needs its own code
  localparam ST_RCYC = 5'h10;

  // Token pulse is a least time: round up to whole clocks
  localparam integer TOKEN_CYC_I = (`SMIA_TOKEN_PULSE_NS +
    `SMIA_CLK_PERIOD_NS - 1) / `SMIA_CLK_PERIOD_NS;
  localparam [1:0] TOKEN_CYC = TOKEN_CYC_I[1:0];

  function [`SMIA_RQ_N-1:0] pick;
    input [`SMIA_RQ_N-1:0] pend;
    begin
      pick = pend & (~pend + 5'h01);
    end
  endfunction

  function is_dram;
    input [2:0] kind;
    begin
      is_dram = (kind == `SMIA_KIND_DRAM256) ||
        (kind == `SMIA_KIND_DRAM1M) || (kind == `SMIA_KIND_DRAM4M);
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Pin synchronisers

  reg [1:0] sel_sync_q;
  reg [1:0] tin_sync_q;
  reg [1:0] tfirst_sync_q;
  reg tin_last_q;
  reg [23:0] caddr_s1_q, caddr_q;
  reg [1:0] cctl_s1_q, cctl_q;

  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      sel_sync_q <= 2'h3;
      tin_sync_q <= 2'h0;
      tfirst_sync_q <= 2'h0;
      tin_last_q <= 1'b0;
      caddr_s1_q <= 24'h0;
      caddr_q <= 24'h0;
      cctl_s1_q <= 2'h0;
      cctl_q <= 2'h0;
    end else begin
      sel_sync_q <= {sel_sync_q[0], memory_select_n};
      tin_sync_q <= {tin_sync_q[0], token_in};
      tfirst_sync_q <= {tfirst_sync_q[0], token_first};
      tin_last_q <= tin_sync_q[1];
      caddr_s1_q <= cpu_addr;
      caddr_q <= caddr_s1_q;
      cctl_s1_q <= {cpu_byte, cpu_write};
      cctl_q <= cctl_s1_q;
    end
  end

  wire cpu_sel;
  wire tin_rise;
  assign cpu_sel = ~sel_sync_q[1]; // RULE_16
  assign tin_rise = tin_sync_q[1] & ~tin_last_q;

  ////////////////////////////////////////////////////////////////////////
  // Request selection

  reg [4:0] state_q;
  reg [3:0] cnt_q;
  reg [`SMIA_RQ_N-1:0] grant_q;
  reg [`SMIA_RQ_N-1:0] done_q;
  reg cpu_served_q;
  reg ref_pend_q;
  reg [11:0] ref_cnt_q;
  reg [10:0] ref_row_q;
  reg hold_q;
  reg [1:0] init_q;
  reg [1:0] tok_cnt_q;
  reg token_out_q;
  reg [7:0] ce_n_q;
  reg [3:0] ras_n_q;
  reg [1:0] cas_n_q;
  reg [1:0] cas_pat_q;
  reg [18:0] addr_q;
  reg [10:0] col_q;
  reg we_n_q;

  wire [`SMIA_RQ_N-1:0] pend;
  wire [`SMIA_RQ_N-1:0] win;
  assign pend = {ref_pend_q, ic_req, tx_req,
    cpu_sel & ~cpu_served_q, rx_req};
  assign win = pick(pend); // RULE_13

  reg [23:0] sel_addr;
  reg sel_byte;
  reg sel_write;
  always @* begin
    sel_addr = rx_addr;
    sel_byte = rx_byte;
    sel_write = rx_write;
    if (win[`SMIA_RQ_CPU]) begin
      sel_addr = caddr_q;
      sel_byte = cctl_q[1];
      sel_write = cctl_q[0];
    end else if (win[`SMIA_RQ_TX]) begin
      sel_addr = tx_addr;
      sel_byte = tx_byte;
      sel_write = tx_write;
    end else if (win[`SMIA_RQ_IC]) begin
      sel_addr = ic_addr;
      sel_byte = ic_byte;
      sel_write = ic_write;
    end
  end

  wire [7:0] map_ce_n;
  wire [3:0] map_ras_n;
  wire [1:0] map_cas_n;
  wire [18:0] map_word;
  wire [10:0] map_row;
  wire [10:0] map_col;

  smia_addr_map smia_addr_map_i (
    .addr(sel_addr),
    .kind(mem_kind),
    .byte_xfer(sel_byte),
    .ce_n(map_ce_n),
    .ras_n(map_ras_n),
    .cas_n(map_cas_n),
    .word_addr(map_word),
    .row(map_row),
    .col(map_col)
  );

  wire dram;
  wire may_go;
  wire init_done;
  wire [3:0] dlen;
  assign dram = is_dram(mem_kind);
  assign init_done = (init_q == `SMIA_INIT_DONE);
  assign may_go = ~chain_enable | hold_q; // RULE_17
  // Row phase takes one clock, so a DRAM cycle is never below two
  assign dlen = (dram_cycle_len < `SMIA_MIN_DRAM_LEN) ?
    `SMIA_MIN_DRAM_LEN : dram_cycle_len;

  ////////////////////////////////////////////////////////////////////////
  // Refresh timer; the tick wins over the grant that clears it

  wire ref_tick;
  wire ref_take;
  // At or past the period, so a lowered period acts without a wrap
  assign ref_tick = dram && (ref_cnt_q >= refresh_period);
  assign ref_take = (state_q == ST_IDLE) && init_done && may_go &&
    win[`SMIA_RQ_REF];

  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ref_cnt_q <= 12'h0;
      ref_pend_q <= 1'b0;
    end else begin
      ref_cnt_q <= ref_tick ? 12'h0 : ref_cnt_q + 12'h001; // RULE_09
      if (ref_tick) begin
        ref_pend_q <= 1'b1; // RULE_09
      end else if (ref_take) begin
        ref_pend_q <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Cycle engine

  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state_q <= ST_IDLE;
      cnt_q <= 4'h0;
      grant_q <= 5'h00;
      done_q <= 5'h00;
      cpu_served_q <= 1'b0;
      ref_row_q <= 11'h0;
      hold_q <= 1'b0;
      init_q <= 2'h0;
      tok_cnt_q <= 2'h0;
      token_out_q <= 1'b0;
      ce_n_q <= 8'hff;
      ras_n_q <= 4'hf;
      cas_n_q <= 2'h3;
      cas_pat_q <= 2'h3;
      addr_q <= 19'h0;
      col_q <= 11'h0;
      we_n_q <= 1'b1;
    end else begin
      done_q <= 5'h00;
      if (!init_done) begin
        init_q <= init_q + 2'h1;
      end
      if (!cpu_sel) begin
        cpu_served_q <= 1'b0;
      end
      // First holder of the token is strapped, caught after release
      if (!init_done) begin
        hold_q <= tfirst_sync_q[1];
      end else if (tin_rise) begin
        hold_q <= 1'b1; // RULE_14 RULE_17
      end
      if (tok_cnt_q != 2'h0) begin
        tok_cnt_q <= tok_cnt_q - 2'h1;
        token_out_q <= 1'b1; // RULE_15
      end else begin
        token_out_q <= 1'b0;
      end
      case (state_q)
        ST_IDLE: begin
          if (init_done && may_go && (pend != 5'h00)) begin
            grant_q <= win;
            we_n_q <= ~sel_write;
            if (win[`SMIA_RQ_REF]) begin
              ras_n_q <= 4'h0; // RULE_09
              addr_q <= {8'h00, ref_row_q};
              ref_row_q <= ref_row_q + 11'h001; // RULE_09
              we_n_q <= 1'b1;
              cnt_q <= dlen; // RULE_01
              state_q <= ST_RCYC;
            end else if (dram) begin
              ras_n_q <= map_ras_n; // RULE_07 RULE_08
              addr_q <= {8'h00, map_row}; // RULE_07
              col_q <= map_col;
              cas_pat_q <= map_cas_n;
              cnt_q <= dlen; // RULE_01
              state_q <= ST_ROW;
            end else begin
              ce_n_q <= map_ce_n; // RULE_02 RULE_03
              addr_q <= map_word; // RULE_02
              cnt_q <= sram_cycle_len; // RULE_01
              state_q <= ST_SRAM;
            end
          end else if (init_done && chain_enable && hold_q &&
                       (pend == 5'h00) && !tin_rise) begin
            hold_q <= 1'b0; // RULE_14 RULE_15
            tok_cnt_q <= TOKEN_CYC; // RULE_15
          end
        end
        ST_ROW: begin
          addr_q <= {8'h00, col_q}; // RULE_07
          cas_n_q <= cas_pat_q; // RULE_08
          cnt_q <= cnt_q - 4'h1;
          state_q <= ST_COL;
        end
        ST_SRAM, ST_COL, ST_RCYC: begin
          // No new grant until this cycle has run out
          if (cnt_q <= 4'h1) begin
            ce_n_q <= 8'hff; // RULE_18
            ras_n_q <= 4'hf;
            cas_n_q <= 2'h3;
            we_n_q <= 1'b1;
            done_q <= grant_q & ~(5'h01 << `SMIA_RQ_REF);
            if (grant_q[`SMIA_RQ_CPU]) begin
              cpu_served_q <= 1'b1;
            end
            state_q <= ST_IDLE;
          end else begin
            cnt_q <= cnt_q - 4'h1; // RULE_18
          end
        end
        default: begin
          state_q <= ST_IDLE;
        end
      endcase
    end
  end

  assign rx_done = done_q[`SMIA_RQ_RX];
  assign cpu_ready = done_q[`SMIA_RQ_CPU];
  assign tx_done = done_q[`SMIA_RQ_TX];
  assign ic_done = done_q[`SMIA_RQ_IC];
  assign chip_enable_n = ce_n_q;
  assign row_strobe_n = ras_n_q;
  assign column_strobe_n = cas_n_q;
  assign memory_address_bus = addr_q;
  assign mem_write_n = we_n_q;
  assign token_out = token_out_q;

endmodule // smia_arbiter

/* File: smia_arbiter_props.sv */
// Concurrent checks on the arbiter's memory, completion and token pins
`include "smia_defs.vh"

module smia_arbiter_props (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // Configuration
  input wire logic [2:0] mem_kind,
  input wire logic [3:0] sram_cycle_len,
  input wire logic chain_enable,
  // Completions
  input wire logic rx_done,
  input wire logic tx_done,
  input wire logic ic_done,
  input wire logic cpu_ready,
  // Memory and token pins
  input wire logic [7:0] chip_enable_n,
  input wire logic [3:0] row_strobe_n,
  input wire logic [1:0] column_strobe_n,
  input wire logic token_out
);
  timeunit 1ns;
  timeprecision 1ns;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_b);

  wire ce_off = &chip_enable_n;
  wire ras_off = &row_strobe_n;
  wire any_done = rx_done | tx_done | ic_done | cpu_ready;

  ////////////////////////////////////////////////////////////////////////
  // Strobes stand p clocks and drop together with the completion pulse
  sequence s_sram_hold;
    !ce_off [*3] ##1 (ce_off && any_done);
  endsequence

  // Refresh rows carry no column strobe, so only access cycles count here
  sequence s_cas_follows;
    ##1 (column_strobe_n != 2'h3);
  endsequence

  one_enable_a: assert property (!ce_off |-> $onehot(~chip_enable_n))
    else $error("more than one chip enable active");
  sram512_pair_a: assert property (
    mem_kind == `SMIA_KIND_SRAM512 |-> chip_enable_n[7:2] == 6'h3f)
    else $error("upper chip enables used with deep static parts");
  dram_no_ce_a: assert property (
    mem_kind >= `SMIA_KIND_DRAM256 |-> ce_off)
    else $error("chip enable active in dynamic mode");
  sram_len_a: assert property (
    ($fell(ce_off) && sram_cycle_len == 4'h3) |-> s_sram_hold)
    else $error("static cycle length wrong");
  cas_after_ras_a: assert property (
    ($fell(ras_off) && row_strobe_n != 4'h0) |-> s_cas_follows)
    else $error("no column strobe after row strobe");
  refresh_no_cas_a: assert property (
    row_strobe_n == 4'h0 |-> column_strobe_n == 2'h3)
    else $error("column strobe during refresh");
  one_bank_a: assert property (
    row_strobe_n != 4'h0 |-> $onehot0(~row_strobe_n))
    else $error("two banks strobed at once");
  one_done_a: assert property (
    $onehot0({rx_done, tx_done, ic_done, cpu_ready}))
    else $error("two requesters finished together");
  token_width_a: assert property (
    $rose(token_out) |=> token_out ##1 !token_out)
    else $error("token pulse width wrong");
  token_quiet_a: assert property (
    (chain_enable && token_out) |-> (ce_off && ras_off))
    else $error("memory cycle while passing token");
endmodule // smia_arbiter_props

/* File: smia_cpu_model.sv */
// Processor model that reaches shared memory through the memory select
module smia_cpu_model (
  // Control from the bench
  input wire logic clk,
  input wire logic go,
  input wire logic [23:0] addr,
  // Processor pins
  output logic memory_select_n,
  output logic [23:0] cpu_addr,
  output logic cpu_byte,
  output logic cpu_write,
  input wire logic cpu_ready
);
  timeunit 1ns;
  timeprecision 1ns;

  initial begin
    memory_select_n = 1'b1;
    cpu_addr = 24'h0;
    cpu_byte = 1'b0;
    cpu_write = 1'b0;
  end

  // One access per select; address is scrambled once released
  always @(posedge go) begin
    @(posedge clk);
    #2;
    cpu_addr = addr;
    memory_select_n = 1'b0;
    @(posedge clk);
    #2;
    while (cpu_ready !== 1'b1) begin
      @(posedge clk);
      #2;
    end
    memory_select_n = 1'b1;
    cpu_addr = ~addr;
  end
endmodule // smia_cpu_model

/* File: smia_arbiter_tb_top.sv */
// Self-checking bench for the shared memory arbiter
`define CHK(n, e, s) begin tests_run++; if ((s) !== (e)) begin n_errors++; \
  $display("Error %s: expected %h, seen %h", n, e, s); end end

module smia_arbiter_tb_top;
  timeunit 1ns;
  timeprecision 1ns;

  reg clk = 0, rst_b = 0, chain_enable = 0, token_in = 0, token_first = 1;
  reg [2:0] mem_kind = 0;
  reg [3:0] sram_cycle_len = 4'h3, dram_cycle_len = 4'h3;
  reg [11:0] refresh_period = 12'hfff;
  reg rx_req = 0, tx_req = 0, ic_req = 0, rx_byte = 0, tx_byte = 0;
  reg ic_byte = 0, rx_write = 0, tx_write = 0, ic_write = 1, cpu_go = 0;
  reg [23:0] rx_addr = 0, tx_addr = 24'h4, ic_addr = 24'h8, cpu_a = 24'h10;
  wire rx_done, tx_done, ic_done, cpu_ready, mem_write_n, token_out;
  wire memory_select_n, cpu_byte, cpu_write;
  wire [23:0] cpu_addr;
  wire [7:0] chip_enable_n;
  wire [3:0] row_strobe_n;
  wire [1:0] column_strobe_n;
  wire [18:0] memory_address_bus;
  reg [7:0] ce;
  reg [3:0] ras;
  reg [1:0] cas;
  reg we;
  reg [18:0] a0, a1;
  int len, n_errors = 0, tests_run = 0;

  smia_arbiter smia_arbiter_i (.clk, .rst_b, .mem_kind, .sram_cycle_len,
    .dram_cycle_len, .refresh_period, .chain_enable, .rx_req, .rx_addr,
    .rx_byte, .rx_write, .rx_done, .tx_req, .tx_addr, .tx_byte, .tx_write,
    .tx_done, .ic_req, .ic_addr, .ic_byte, .ic_write, .ic_done,
    .memory_select_n, .cpu_addr, .cpu_byte, .cpu_write, .cpu_ready,
    .chip_enable_n, .row_strobe_n, .column_strobe_n, .memory_address_bus,
    .mem_write_n, .token_in, .token_first, .token_out);
  smia_cpu_model smia_cpu_model_i (.clk, .go(cpu_go), .addr(cpu_a),
    .memory_select_n, .cpu_addr, .cpu_byte, .cpu_write, .cpu_ready);

  always #10 clk = ~clk;

  ////////////////////////////////////////////////////////////////////////
  task automatic step(int n = 1);
    repeat (n) @(posedge clk);
    #2;
  endtask

  task automatic pulse;
    token_in = 1;
    step(2);
    token_in = 0;
  endtask

  // Captures the next cycle: selects, row then column, and its length
  task automatic grab;
    int k;
    k = 0;
    while (&chip_enable_n && &row_strobe_n && k < 99) begin
      step();
      k++;
    end
    ce = chip_enable_n;
    ras = row_strobe_n;
    we = mem_write_n;
    a0 = memory_address_bus;
    step();
    cas = column_strobe_n;
    a1 = memory_address_bus;
    len = 1;
    while (!(&chip_enable_n && &row_strobe_n) && len < 20) begin
      step();
      len++;
    end
  endtask

  ////////////////////////////////////////////////////////////////////////
  task automatic t_dram;
    reg [23:0] a;
    reg [1:0] r;
    a = 24'hd6b5a7;
    rx_addr = a;
    rx_req = 1;
    for (int k = 2; k < 5; k++) for (int j = 0; j < 2; j++) begin
      mem_kind = k[2:0];
      rx_byte = j[0];
      rx_write = j[0];
      r = k == 2 ? {a[20], a[19]} : k == 3 ? {a[22], a[20]} : {1'b0, a[23]};
      grab();
      `CHK("ras", ~(4'h1 << r), ras)
      `CHK("row", k == 2 ? a[18:10] : k == 3 ? a[20:11] : a[22:12], a0)
      `CHK("col", k == 2 ? a[9:1] : k == 3 ? a[10:1] : a[11:1], a1)
      `CHK("cas", j ? 2'h1 : 2'h0, cas)
      `CHK("we", j ? 1'b0 : 1'b1, we)
    end
    rx_req = 0;
    rx_byte = 0;
    rx_write = 0;
    step();
  endtask

  task automatic t_sram(input int n, input [3:0] p);
    mem_kind = n == 8 ? 3'h0 : 3'h1;
    sram_cycle_len = p;
    rx_req = 1;
    for (int i = 0; i < n; i++) begin
      rx_addr = n == 8 ? {4'h0, i[2:1], 17'h15a5b, i[0]} : {4'h0, 19'h5a5a5, i[0]};
      grab();
      `CHK("ce", ~(8'h1 << i), ce)
      `CHK("adr", rx_addr[19:1] & (n == 8 ? 19'h1ffff : 19'h7ffff), a0)
      `CHK("len", p, len)
    end
    rx_req = 0;
    step();
  endtask

  task automatic t_prio;
    reg [15:0] o;
    o = 0;
    sram_cycle_len = 4'h3;
    tx_req = 1;
    ic_req = 1;
    step(2);
    rx_req = 1;
    cpu_go = 1;
    for (int k = 0; k < 60; k++) begin
      if (rx_done | cpu_ready | tx_done | ic_done)
        o = {o[11:0], rx_done, cpu_ready, tx_done, ic_done};
      if (rx_done) rx_req = 0;
      if (tx_done) tx_req = 0;
      if (ic_done) ic_req = 0;
      step();
    end
    cpu_go = 0;
    `CHK("order", 16'h2841, o)
  endtask

  task automatic t_token;
    int w;
    w = 0;
    chain_enable = 1;
    step(8);
    pulse();
    for (int k = 0; k < 12; k++) begin
      w += token_out;
      step();
    end
    `CHK("pulse", 2, w)
    rx_addr = 0;
    rx_req = 1;
    step(20);
    `CHK("hold", 8'hff, chip_enable_n)
    pulse();
    grab();
    rx_req = 0;
    `CHK("turn", 3, len)
    chain_enable = 0;
  endtask

  task automatic t_refresh;
    reg [18:0] r0;
    mem_kind = 3'h2;
    dram_cycle_len = 4'h4;
    refresh_period = 12'h00f;
    grab();
    r0 = a0;
    `CHK("ref", 4'h0, ras)
    `CHK("refcas", 2'h3, cas)
    `CHK("reflen", 4, len)
    grab();
    refresh_period = 12'hfff;
    `CHK("refrow", r0 + 19'h1, a0)
    mem_kind = 3'h0;
  endtask

  task automatic give_verdict;
    if (n_errors == 0 && tests_run > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  // Whole run is well under 2000 clocks
  initial begin
    #100us;
    n_errors++;
    give_verdict();
  end

  initial begin
    repeat (16) @(posedge clk);
    #2 rst_b = 1;
    step(3);
    t_dram();
    t_sram(8, 4'h3);
    t_sram(2, 4'h1);
    t_prio();
    t_token();
    t_refresh();
    give_verdict();
  end
endmodule // smia_arbiter_tb_top

bind smia_arbiter smia_arbiter_props smia_arbiter_props_i (.clk, .rst_b,
  .mem_kind, .sram_cycle_len, .chain_enable, .rx_done, .tx_done, .ic_done,
  .cpu_ready, .chip_enable_n, .row_strobe_n, .column_strobe_n, .token_out);
